// ### rtl/bacu_pkg.sv
// Shared constants and types for the byte add-with-carry unit
package bacu_pkg;

  localparam int DATA_W = 8;
  localparam int BANK_W = 2;
  localparam int RSEL_W = 3;
  localparam int RF_AW = BANK_W + RSEL_W;
  localparam int RF_DEPTH = 32;
  localparam int LEN_W = 2;

  // Opcode patterns
  localparam logic [4:0] OP_ADD_REG_PFX = 5'h05;
  localparam logic [6:0] OP_ADD_IND_PFX = 7'h13;
  localparam logic [7:0] OP_ADD_DIR = 8'h25;
  localparam logic [7:0] OP_ADD_IMM = 8'h24;
  localparam logic [4:0] OP_ADD_WITH_CARRY_OP_REG_PFX = 5'h07;
  localparam logic [6:0] OP_ADD_WITH_CARRY_OP_IND_PFX = 7'h1B;
  localparam logic [7:0] OP_ADD_WITH_CARRY_OP_DIR = 8'h35;
  localparam logic [7:0] OP_ADD_WITH_CARRY_OP_IMM = 8'h34;

  // Instruction lengths in bytes
  localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
  localparam logic [LEN_W-1:0] LEN_NONE = 2'h0;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // Indirect pointer lives in working register 0 or 1
  localparam logic [1:0] PTR_REG_HI = 2'h0;

  // Flag and sum bit positions
  localparam int SUM_W = 11;
  localparam int POS_CY = 10;
  localparam int POS_AC = 9;
  localparam int POS_OV = 8;
  localparam int NIB_W = 4;

  typedef enum logic [2:0] {
    BACU_IDLE = 3'h0,
    BACU_REG = 3'h1,
    BACU_ADDR = 3'h3,
    BACU_DATA = 3'h2,
    BACU_EXEC = 3'h6
  } bacu_state_e;

  typedef enum logic [2:0] {
    BACU_SRC_NONE = 3'h0,
    BACU_SRC_REG = 3'h1,
    BACU_SRC_DIR = 3'h2,
    BACU_SRC_IND = 3'h3,
    BACU_SRC_IMM = 3'h4
  } bacu_src_e;

endpackage : bacu_pkg

// ### rtl/bacu_regfile.sv
// Working register banks with a registered read port
`timescale 1ns/100ps
`default_nettype none

module bacu_regfile #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;

  always_comb begin
    rd_data_next = mem[rd_addr];
  end

  // Storage has no reset, as in a real RAM; only the read register has one
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule : bacu_regfile

`default_nettype wire

// ### rtl/bacu_unit.sv
// Decode and execute of the 8-bit add and add-with-carry instructions
`timescale 1ns/100ps
`default_nettype none

module bacu_unit
  import bacu_pkg::*;
#(
  parameter int DW = DATA_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Instruction issue
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [DATA_W-1:0] opcode_in,
  input wire logic [DATA_W-1:0] operand_in,
  // Completion
  output logic instr_done,
  output logic instr_illegal,
  output logic [LEN_W-1:0] instr_len,
  // Working registers
  input wire logic [BANK_W-1:0] bank_sel,
  input wire logic rf_wr_en,
  input wire logic [RF_AW-1:0] rf_wr_addr,
  input wire logic [DATA_W-1:0] rf_wr_data,
  // Internal RAM read
  output logic ram_rd,
  output logic [DATA_W-1:0] ram_addr,
  input wire logic [DATA_W-1:0] ram_rdata,
  // Accumulator and flags load from the core
  input wire logic acc_wr_en,
  input wire logic [DATA_W-1:0] acc_wr_data,
  input wire logic flag_wr_en,
  input wire logic carry_in,
  input wire logic half_carry_in,
  input wire logic overflow_in,
  // Accumulator and flags
  output logic [DATA_W-1:0] acc,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic signed_overflow_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and arithmetic helpers

  function automatic bacu_src_e decode_src(input logic [DATA_W-1:0] op);
    bacu_src_e m;
    m = BACU_SRC_NONE;
    if (op[7:3] == OP_ADD_REG_PFX || op[7:3] == OP_ADD_WITH_CARRY_OP_REG_PFX) begin
      m = BACU_SRC_REG;
    end else if (op[7:1] == OP_ADD_IND_PFX || op[7:1] == OP_ADD_WITH_CARRY_OP_IND_PFX) begin
      m = BACU_SRC_IND;
    end else if (op == OP_ADD_DIR || op == OP_ADD_WITH_CARRY_OP_DIR) begin
      m = BACU_SRC_DIR;
    end else if (op == OP_ADD_IMM || op == OP_ADD_WITH_CARRY_OP_IMM) begin
      m = BACU_SRC_IMM;
    end
    return m;
  endfunction : decode_src

  function automatic logic decode_with_carry(input logic [DATA_W-1:0] op);
    return (op[7:3] == OP_ADD_WITH_CARRY_OP_REG_PFX) || (op[7:1] == OP_ADD_WITH_CARRY_OP_IND_PFX) ||
           (op == OP_ADD_WITH_CARRY_OP_DIR) || (op == OP_ADD_WITH_CARRY_OP_IMM);
  endfunction : decode_with_carry

  // Returns {carry, half carry, overflow, sum}
  function automatic logic [SUM_W-1:0] add8(input logic [DATA_W-1:0] a,
                                             input logic [DATA_W-1:0] b,
                                             input logic c);
    logic [NIB_W:0] nib;
    logic [DATA_W-1:0] low7;
    logic [DATA_W:0] full;
    nib = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]} + {{NIB_W{1'b0}}, c};
    low7 = {1'b0, a[DATA_W-2:0]} + {1'b0, b[DATA_W-2:0]} +
           {{(DATA_W-1){1'b0}}, c};
    full = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, c};
    return {full[DATA_W], nib[NIB_W], low7[DATA_W-1] ^ full[DATA_W],
            full[DATA_W-1:0]};
  endfunction : add8

  ////////////////////////////////////////////////////////////////////////////
  // State

  bacu_state_e state_reg, state_next;
  bacu_src_e src_mode;
  logic with_carry_reg, with_carry_next;
  logic [DATA_W-1:0] src_reg, src_next;
  logic [DATA_W-1:0] ram_addr_reg, ram_addr_next;
  logic ram_rd_reg, ram_rd_next;
  logic [DATA_W-1:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic half_carry_reg, half_carry_next;
  logic overflow_reg, overflow_next;
  logic done_reg, done_next;
  logic illegal_reg, illegal_next;
  logic [LEN_W-1:0] len_reg, len_next;
  logic [LEN_W-1:0] len_hold_reg, len_hold_next;
  // Opcode is held so the register state knows which path it is on
  logic [DATA_W-1:0] opcode_hold_reg, opcode_hold_next;
  logic [RF_AW-1:0] rf_rd_addr;
  logic [DATA_W-1:0] rf_rd_data;
  logic [SUM_W-1:0] result;
  logic accept;

  assign instr_ready = (state_reg == BACU_IDLE);
  assign accept = instr_valid && instr_ready;
  assign src_mode = decode_src(opcode_in);

  // The register read is issued while the opcode is offered, so the data
  // is back when the sequencer reaches the register state
  always_comb begin
    if (src_mode == BACU_SRC_IND) begin
      rf_rd_addr = {bank_sel, PTR_REG_HI, opcode_in[0]};
    end else begin
      rf_rd_addr = {bank_sel, opcode_in[RSEL_W-1:0]};
    end
  end

  bacu_regfile #(
    .WIDTH(DATA_W),
    .DEPTH(RF_DEPTH),
    .AW(RF_AW)
  ) u_regfile (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(rf_wr_en),
    .wr_addr(rf_wr_addr),
    .wr_data(rf_wr_data),
    .rd_addr(rf_rd_addr),
    .rd_data(rf_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one pass per instruction

  assign result = add8(acc_reg, src_reg, with_carry_reg & carry_reg);

  always_comb begin
    state_next = state_reg;
    with_carry_next = with_carry_reg;
    src_next = src_reg;
    ram_addr_next = ram_addr_reg;
    ram_rd_next = 1'b0;
    done_next = 1'b0;
    illegal_next = 1'b0;
    len_next = len_reg;
    len_hold_next = len_hold_reg;
    case (state_reg)
      BACU_IDLE: begin
        if (accept) begin
          with_carry_next = decode_with_carry(opcode_in);
          case (src_mode)
            BACU_SRC_REG: begin
              len_hold_next = LEN_ONE;
              state_next = BACU_REG;
            end
            BACU_SRC_IND: begin
              len_hold_next = LEN_ONE;
              state_next = BACU_REG;
            end
            BACU_SRC_DIR: begin
              len_hold_next = LEN_TWO;
              ram_addr_next = operand_in;
              ram_rd_next = 1'b1;
              state_next = BACU_ADDR;
            end
            BACU_SRC_IMM: begin
              len_hold_next = LEN_TWO;
              src_next = operand_in;
              state_next = BACU_EXEC;
            end
            default: begin
              // Foreign opcodes belong to other units: flag, touch nothing
              illegal_next = 1'b1;
              len_next = LEN_NONE;
            end
          endcase
        end
      end
      BACU_REG: begin
        if (decode_src(opcode_hold_reg) == BACU_SRC_IND) begin
          ram_addr_next = rf_rd_data;
          ram_rd_next = 1'b1;
          state_next = BACU_ADDR;
        end else begin
          src_next = rf_rd_data;
          state_next = BACU_EXEC;
        end
      end
      BACU_ADDR: begin
        state_next = BACU_DATA;
      end
      BACU_DATA: begin
        src_next = ram_rdata;
        state_next = BACU_EXEC;
      end
      BACU_EXEC: begin
        done_next = 1'b1;
        len_next = len_hold_reg;
        state_next = BACU_IDLE;
      end
      default: begin
        state_next = BACU_IDLE;
      end
    endcase
  end

  always_comb begin
    opcode_hold_next = accept ? opcode_in : opcode_hold_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags

  // The instruction result wins over a core load in the same cycle, so a
  // finished add is never lost behind a stale write
  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    half_carry_next = half_carry_reg;
    overflow_next = overflow_reg;
    if (state_reg == BACU_EXEC) begin
      acc_next = result[DATA_W-1:0];
      carry_next = result[POS_CY];
      half_carry_next = result[POS_AC];
      overflow_next = result[POS_OV];
    end else begin
      if (acc_wr_en) begin
        acc_next = acc_wr_data;
      end
      if (flag_wr_en) begin
        carry_next = carry_in;
        half_carry_next = half_carry_in;
        overflow_next = overflow_in;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= BACU_IDLE;
      with_carry_reg <= 1'b0;
      src_reg <= '0;
      ram_addr_reg <= '0;
      ram_rd_reg <= 1'b0;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      len_reg <= LEN_NONE;
      len_hold_reg <= LEN_NONE;
      opcode_hold_reg <= '0;
      acc_reg <= ACC_RESET;
      carry_reg <= FLAG_RESET;
      half_carry_reg <= FLAG_RESET;
      overflow_reg <= FLAG_RESET;
    end else begin
      state_reg <= state_next;
      with_carry_reg <= with_carry_next;
      src_reg <= src_next;
      ram_addr_reg <= ram_addr_next;
      ram_rd_reg <= ram_rd_next;
      done_reg <= done_next;
      illegal_reg <= illegal_next;
      len_reg <= len_next;
      len_hold_reg <= len_hold_next;
      opcode_hold_reg <= opcode_hold_next;
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      half_carry_reg <= half_carry_next;
      overflow_reg <= overflow_next;
    end
  end

  assign ram_rd = ram_rd_reg;
  assign ram_addr = ram_addr_reg;
  assign instr_done = done_reg;
  assign instr_illegal = illegal_reg;
  assign instr_len = len_reg;
  assign acc = acc_reg;
  assign carry_flag = carry_reg;
  assign half_carry_flag = half_carry_reg;
  assign signed_overflow_flag = overflow_reg;

endmodule : bacu_unit

`default_nettype wire

// ### test/bacu_unit_chk.sv
// Timing and decode checker for the byte add unit
`timescale 1ns/100ps
`default_nettype none

module bacu_unit_chk
  import bacu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Issue
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [DATA_W-1:0] opcode_in,
  input wire logic [DATA_W-1:0] operand_in,
  // Completion and memory
  input wire logic instr_done,
  input wire logic instr_illegal,
  input wire logic [LEN_W-1:0] instr_len,
  input wire logic ram_rd,
  input wire logic [DATA_W-1:0] ram_addr,
  // Accumulator
  input wire logic acc_wr_en,
  input wire logic [DATA_W-1:0] acc
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic take, grp, imm, rsrc, dsrc, isrc, legal;
  assign take = instr_valid && instr_ready;
  assign grp = take && opcode_in[7:5] == 3'h1;
  assign imm = grp && opcode_in[3:0] == 4'h4;
  assign rsrc = grp && opcode_in[3];
  assign dsrc = grp && opcode_in[3:0] == 4'h5;
  assign isrc = grp && opcode_in[3:1] == 3'h3;
  assign legal = grp && (opcode_in[3] || opcode_in[2]);

  ////////////////////////////////////////////////////////////////////////
  sequence s_fetch;
    ##1 ram_rd && ram_addr == $past(operand_in);
  endsequence
  sequence s_ptr_fetch;
    ##2 ram_rd;
  endsequence

  property p_imm;
    imm |-> ##2 instr_done && instr_len == LEN_TWO;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate add timing");
  property p_reg;
    rsrc |-> ##3 instr_done && instr_len == LEN_ONE;
  endproperty
  a_reg: assert property (p_reg) else $error("register add timing");
  property p_dir;
    dsrc |-> s_fetch ##3 instr_done && instr_len == LEN_TWO;
  endproperty
  a_dir: assert property (p_dir) else $error("direct add timing");
  property p_ind;
    isrc |-> s_ptr_fetch ##3 instr_done && instr_len == LEN_ONE;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect add timing");
  property p_illegal;
    take && !legal |=> instr_illegal && !instr_done && instr_len == LEN_NONE;
  endproperty
  a_illegal: assert property (p_illegal) else $error("bad opcode");
  // Loads and results are the only ways the accumulator may move
  property p_acc;
    $past(resetn) && !instr_done && !$past(acc_wr_en) |-> $stable(acc);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator moved");
  property p_busy;
    legal |=> !instr_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_done;
    instr_done |-> instr_ready && !ram_rd && !instr_illegal;
  endproperty
  a_done: assert property (p_done) else $error("done state");
endmodule : bacu_unit_chk

bind bacu_unit bacu_unit_chk u_chk (.ref_clk, .resetn, .instr_valid,
  .instr_ready, .opcode_in, .operand_in, .instr_done, .instr_illegal,
  .instr_len, .ram_rd, .ram_addr, .acc_wr_en, .acc);

`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the byte add unit
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import bacu_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, rf_wr_en = 1'b0;
  logic acc_wr_en = 1'b0, flag_wr_en = 1'b0, carry_in = 1'b0;
  logic half_carry_in = 1'b0, overflow_in = 1'b0, rd_d = 1'b0;
  logic [7:0] opcode_in = 8'h00, operand_in = 8'h00, rf_wr_data = 8'h00;
  logic [7:0] ram_rdata = 8'h00, acc_wr_data = 8'h00;
  logic [4:0] rf_wr_addr = 5'h00;
  logic [1:0] bank_sel = 2'h0;
  logic instr_ready, instr_done, instr_illegal, ram_rd;
  logic carry_flag, half_carry_flag, signed_overflow_flag;
  logic [1:0] instr_len;
  logic [7:0] ram_addr, acc, acc_m;
  logic cy_m;
  int errors = 0, total_checks = 0;

  bacu_unit u_dut (.ref_clk, .resetn, .instr_valid, .instr_ready, .opcode_in,
    .operand_in, .instr_done, .instr_illegal, .instr_len, .bank_sel,
    .rf_wr_en, .rf_wr_addr, .rf_wr_data, .ram_rd, .ram_addr, .ram_rdata,
    .acc_wr_en, .acc_wr_data, .flag_wr_en, .carry_in, .half_carry_in,
    .overflow_in, .acc, .carry_flag, .half_carry_flag, .signed_overflow_flag);

  always #12.5 ref_clk = ~ref_clk;
  // Read data is valid only in the cycle after the request
  always @(posedge ref_clk) rd_d <= ram_rd;
  always @(negedge ref_clk) begin
    ram_rdata <= rd_d ? ram_addr ^ 8'hA5 : ~(ram_addr ^ 8'hA5);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic load(input logic [7:0] a, input logic c);
    @(negedge ref_clk);
    acc_wr_en = 1'b1;
    acc_wr_data = a;
    flag_wr_en = 1'b1;
    carry_in = c;
    @(negedge ref_clk);
    acc_wr_en = 1'b0;
    flag_wr_en = 1'b0;
    acc_m = a;
    cy_m = c;
  endtask : load

  task automatic wr_rf(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    rf_wr_en = 1'b1;
    rf_wr_addr = a;
    rf_wr_data = d;
    @(negedge ref_clk);
    rf_wr_en = 1'b0;
  endtask : wr_rf

  // Issue one instruction and compare against a bit-level add model
  task automatic run(input logic [7:0] op, opr, src, input int lat,
                     input logic [1:0] len);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    logic c;
    int n;
    c = op[4] & cy_m;
    s = acc_m + src + c;
    h = acc_m[3:0] + src[3:0] + c;
    l = acc_m[6:0] + src[6:0] + c;
    @(negedge ref_clk);
    instr_valid = 1'b1;
    opcode_in = op;
    operand_in = opr;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    operand_in = ~opr;
    n = 1;
    while (instr_done !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    check(8'(n), 8'(lat));
    // A hang ends the run here, counted as a mismatch above
    if (n >= 8) begin
      report_and_stop();
    end else begin
      check(acc, s[7:0]);
      check(8'(carry_flag), 8'(s[8]));
      check(8'(half_carry_flag), 8'(h[4]));
      check(8'(signed_overflow_flag), 8'(l[7] ^ s[8]));
      check(8'(instr_len), 8'(len));
      acc_m = s[7:0];
      cy_m = s[8];
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(8'(instr_ready), 8'h01);
    check(acc, 8'h00);
    check(8'(carry_flag), 8'h00);
  endtask : t_reset

  task automatic t_imm;
    load(8'h7F, 1'b1);
    run(8'h24, 8'h01, 8'h01, 2, LEN_TWO);
    run(8'h34, 8'hFF, 8'hFF, 2, LEN_TWO);
    run(8'h34, 8'h00, 8'h00, 2, LEN_TWO);
  endtask : t_imm

  // Bank 0 holds the inverse, so a wrong bank shows in the sum
  task automatic t_reg;
    logic [7:0] v;
    bank_sel = 2'h2;
    for (int r = 0; r < 8; r++) begin
      v = 8'h1F + 8'(r) * 8'h21;
      wr_rf({2'h2, 3'(r)}, v);
      wr_rf({2'h0, 3'(r)}, ~v);
      run(8'h28 | 8'(r), 8'h00, v, 3, LEN_ONE);
      run(8'h38 | 8'(r), 8'h00, v, 3, LEN_ONE);
    end
  endtask : t_reg

  task automatic t_dir;
    load(8'hF0, 1'b1);
    run(8'h25, 8'h3C, 8'h3C ^ 8'hA5, 4, LEN_TWO);
    run(8'h35, 8'hC3, 8'hC3 ^ 8'hA5, 4, LEN_TWO);
  endtask : t_dir

  task automatic t_ind;
    logic [7:0] ptr;
    bank_sel = 2'h1;
    wr_rf(5'h08, 8'h40);
    wr_rf(5'h09, 8'h81);
    for (int i = 0; i < 4; i++) begin
      ptr = i[0] ? 8'h81 : 8'h40;
      run(8'h26 + 8'(i[0]) + 8'(i[1]) * 8'h10, 8'h00, ptr ^ 8'hA5, 5,
          LEN_ONE);
    end
  endtask : t_ind

  task automatic t_illegal;
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      instr_valid = 1'b1;
      opcode_in = i[0] ? 8'h33 : 8'h23;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      check(8'(instr_illegal), 8'h01);
      check(acc, acc_m);
      check(8'(instr_len), 8'(LEN_NONE));
    end
  endtask : t_illegal

  initial begin
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset();
    t_imm();
    t_reg();
    t_dir();
    t_ind();
    t_illegal();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
